// File: rtl/chg_consts.svh
// constants for the charger control and status block
`ifndef CHG_CONSTS_SVH
`define CHG_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define CHG_OFF_CTRL      12'h000
`define CHG_OFF_STATUS    12'h004
`define CHG_OFF_REPLY     12'h008
`define CHG_OFF_INPUTS    12'h00C

// ----------------------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------------------
`define CHG_CTRL_EN_BIT   0
`define CHG_CTRL_LVL_BIT  1
`define CHG_CTRL_REQ_BIT  2
`define CHG_CTRL_RST      32'h0000_0001

// ----------------------------------------------------------------------------
// reply codes (low pulse counts)
// ----------------------------------------------------------------------------
`define CHG_CODE_DIE_OT   5'h01
`define CHG_CODE_BAT_TEMP 5'h02
`define CHG_CODE_OVP      5'h03
`define CHG_CODE_HI_BASE  5'h0D
`define CHG_CODE_LO_BASE  5'h12
`define CHG_CODE_ERROR    5'h17

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CHG_CLK_HZ        20000000
`define CHG_REQ_MIN_NS    200
`define CHG_REQ_CYC       ((`CHG_REQ_MIN_NS * (`CHG_CLK_HZ / 1000000) + 999) / 1000)
`define CHG_DATA_HZ       20000
`define CHG_HALF_CYC      (`CHG_CLK_HZ / `CHG_DATA_HZ / 2)
`define CHG_FLASH_CYC     2000000
`define CHG_TERM_PCT_X10  75

`endif

// File: rtl/chg_pkg.sv
// types for the charger control and status block
package chg_pkg;
    typedef enum logic [2:0] {
        CHG_SLEEP   = 3'b000,
        CHG_PRECOND = 3'b001,
        CHG_CC      = 3'b010,
        CHG_CV      = 3'b011,
        CHG_DONE    = 3'b100,
        CHG_FAULT   = 3'b101
    } chg_phase_e;

    typedef enum logic [1:0] {
        CHG_R_IDLE = 2'b00,
        CHG_R_LOW  = 2'b01,
        CHG_R_HIGH = 2'b10
    } chg_reply_e;
endpackage

// File: rtl/chg_ctrl.sv
// charger control, fault shutdown, status lamps and status line reply
//
// How it works
// RQ1 - level select high picks high current; CTRL level bit set inverts it
// RQ2 - supply sag enters reduction until recovery
// RQ3 - supply lockout suspends charging, shuts down
// RQ4 - lockout clearing restarts in suitable mode
// RQ5 - enable low forces sleep, halts charging
// RQ6 - enable return resets control and restarts
// RQ7 - over-voltage holds shutdown until it clears
// RQ8 - over-voltage shows fault lamps and code
// RQ9 - die over-temperature stops charging
// RQ10 - battery temperature fault stops, reports, lamps
// RQ11 - battery temperature fault clearing resumes charge
// RQ12 - temperature checked before and during charge
// RQ13 - thermistor valid only inside window
// RQ14 - disabled or low supply: lamps off
// RQ15 - enabled without cell: lamps flash
// RQ16 - lamps: charging A, done B, fault both
// RQ17 - lamps are open switches to ground
// RQ18 - host reads one of fourteen states
// RQ19 - host request low pulse, reply after rise
// RQ20 - reply is a count of low pulses
// RQ21 - reply pulses at 20 kHz
// RQ22 - taper to 7.5 percent ends charge
// RQ23 - lamp flash from fixed counter
// RQ24 - fault report priority die, battery, voltage
`timescale 1ns/1ps
`include "chg_consts.svh"

module chg_ctrl #(
    parameter int FLASH_CYC = `CHG_FLASH_CYC
) (
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // analog comparator levels (asynchronous)
    input  wire logic                   charge_level_select,
    input  wire logic                   enable,
    input  wire logic                   supply_lockout,
    input  wire logic                   supply_sag,
    input  wire logic                   cell_present,
    input  wire logic                   cell_below_min,
    input  wire logic                   cell_at_reg,
    input  wire logic                   cell_below_recharge,
    input  wire logic                   cell_overvoltage,
    input  wire logic                   taper_reached,
    input  wire logic                   die_overtemp,
    input  wire logic                   therm_below_hot,
    input  wire logic                   therm_above_cold,
    // charge path control
    output logic                        charge_on,
    output logic                        high_current_level,
    output logic                        low_current_level,
    output logic                        reduction_active,
    output logic                        precond_current,
    // status lamps, open drain
    output logic                        status_lamp_a_o,
    output logic                        status_lamp_a_oe,
    output logic                        status_lamp_b_o,
    output logic                        status_lamp_b_oe,
    // status line, open drain, active low
    input  wire logic                   status_line_i,
    output logic                        status_line_o,
    output logic                        status_line_oe
);
    import chg_pkg::*;

    localparam int NSYNC = 14;
    localparam int REQ_CYC = `CHG_REQ_CYC;
    localparam int HALF_CYC = `CHG_HALF_CYC;

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_reg;
    logic [NSYNC-1:0] s2_reg;

    assign raw_in = {status_line_i, therm_above_cold, therm_below_hot, die_overtemp,
                     taper_reached, cell_overvoltage, cell_below_recharge, cell_at_reg,
                     cell_below_min, cell_present, supply_sag, supply_lockout, enable,
                     charge_level_select};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 14'h2000;
            s2_reg <= 14'h2000;
        end else begin
            s1_reg <= raw_in;
            s2_reg <= s1_reg;
        end
    end

    logic lvl_pin, en_pin, lockout, sag, present, below_min, at_reg, below_rch;
    logic ovp, taper, die_ot, th_hot, th_cold, line_s;
    assign {line_s, th_cold, th_hot, die_ot, taper, ovp, below_rch, at_reg, below_min,
            present, sag, lockout, en_pin, lvl_pin} = s2_reg;

    // ------------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        err_reg;
    logic        err_next;
    logic [4:0]  last_code_reg;
    logic [4:0]  last_code_next;
    logic        sw_req;
    logic        wr_en;
    logic        rd_en;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == `CHG_OFF_CTRL) || (a == `CHG_OFF_STATUS) ||
                  (a == `CHG_OFF_REPLY) || (a == `CHG_OFF_INPUTS);
    endfunction

    // ------------------------------------------------------------------------
    // charge phase machine
    // ------------------------------------------------------------------------
    chg_phase_e phase_reg;
    chg_phase_e phase_next;
    logic       run_en;
    logic       en_d_reg;
    logic       therm_bad;
    logic       any_fault;
    logic       hi_level;
    logic [4:0] code;

    assign run_en    = en_pin && ctrl_reg[`CHG_CTRL_EN_BIT];
    assign therm_bad = th_hot || th_cold;                            // see RQ13
    assign any_fault = die_ot || therm_bad || ovp;
    assign hi_level  = lvl_pin ^ ctrl_reg[`CHG_CTRL_LVL_BIT];        // see RQ1

    always_comb begin
        phase_next = phase_reg;
        if (!run_en || lockout || !present) begin
            phase_next = CHG_SLEEP;                                  // see RQ3, RQ5
        end else if (run_en && !en_d_reg) begin
            phase_next = CHG_SLEEP;                                  // see RQ6
        end else if (any_fault) begin
            phase_next = CHG_FAULT;                                  // see RQ7, RQ9, RQ10, RQ12
        end else begin
            unique case (phase_reg)
                CHG_SLEEP, CHG_FAULT: begin
                    // re-assess the cell on every restart, see RQ4, RQ11
                    phase_next = below_min ? CHG_PRECOND : (at_reg ? CHG_CV : CHG_CC);
                end
                CHG_PRECOND: begin
                    if (!below_min) begin
                        phase_next = CHG_CC;
                    end
                end
                CHG_CC: begin
                    if (at_reg) begin
                        phase_next = CHG_CV;
                    end
                end
                CHG_CV: begin
                    if (taper) begin
                        phase_next = CHG_DONE;                       // see RQ22
                    end
                end
                CHG_DONE: begin
                    if (below_rch) begin
                        phase_next = CHG_CC;
                    end
                end
                default: phase_next = CHG_SLEEP;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= CHG_SLEEP;
            en_d_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            en_d_reg  <= run_en;
        end
    end

    logic charging;
    assign charging = (phase_reg == CHG_PRECOND) || (phase_reg == CHG_CC) ||
                      (phase_reg == CHG_CV);

    // ------------------------------------------------------------------------
    // report code
    // ------------------------------------------------------------------------
    always_comb begin
        if (die_ot) begin
            code = `CHG_CODE_DIE_OT;                                 // see RQ24
        end else if (therm_bad) begin
            code = `CHG_CODE_BAT_TEMP;                               // see RQ10
        end else if (ovp) begin
            code = `CHG_CODE_OVP;                                    // see RQ8
        end else begin
            unique case (phase_reg)
                CHG_PRECOND: code = hi_level ? `CHG_CODE_HI_BASE : `CHG_CODE_LO_BASE;
                CHG_CC:      code = (hi_level ? `CHG_CODE_HI_BASE : `CHG_CODE_LO_BASE) +
                                    (sag ? 5'h01 : 5'h02);
                CHG_CV:      code = (hi_level ? `CHG_CODE_HI_BASE : `CHG_CODE_LO_BASE) + 5'h03;
                CHG_DONE:    code = (hi_level ? `CHG_CODE_HI_BASE : `CHG_CODE_LO_BASE) + 5'h04;
                default:     code = `CHG_CODE_ERROR;                 // see RQ18, RQ20
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // flash counter and lamps
    // ------------------------------------------------------------------------
    logic [31:0] flash_cnt_reg;
    logic [31:0] flash_cnt_next;
    logic        flash_reg;
    logic        flash_next;
    logic        lamp_a_on;
    logic        lamp_b_on;

    always_comb begin
        flash_cnt_next = flash_cnt_reg + 32'h0000_0001;
        flash_next     = flash_reg;
        if (flash_cnt_reg >= 32'(FLASH_CYC - 1)) begin
            flash_cnt_next = 32'h0000_0000;
            flash_next     = !flash_reg;                             // see RQ23
        end
        if (!run_en || lockout) begin
            lamp_a_on = 1'b0;                                        // see RQ14
            lamp_b_on = 1'b0;
        end else if (any_fault) begin
            lamp_a_on = 1'b1;                                        // see RQ16
            lamp_b_on = 1'b1;
        end else if (!present) begin
            lamp_a_on = flash_reg;                                   // see RQ15
            lamp_b_on = flash_reg;
        end else begin
            lamp_a_on = charging;
            lamp_b_on = (phase_reg == CHG_DONE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cnt_reg    <= 32'h0000_0000;
            flash_reg        <= 1'b0;
            status_lamp_a_oe <= 1'b0;
            status_lamp_b_oe <= 1'b0;
        end else begin
            flash_cnt_reg    <= flash_cnt_next;
            flash_reg        <= flash_next;
            status_lamp_a_oe <= lamp_a_on;                           // see RQ17
            status_lamp_b_oe <= lamp_b_on;
        end
    end
    // sink only: never drive high, high impedance when off
    assign status_lamp_a_o = 1'b0;
    assign status_lamp_b_o = 1'b0;

    // ------------------------------------------------------------------------
    // charge path outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charge_on          <= 1'b0;
            high_current_level <= 1'b0;
            low_current_level  <= 1'b0;
            reduction_active   <= 1'b0;
            precond_current    <= 1'b0;
        end else begin
            charge_on          <= charging && !any_fault;            // see RQ9, RQ12
            high_current_level <= charging && hi_level;              // see RQ1
            low_current_level  <= charging && !hi_level;
            reduction_active   <= charging && sag;                   // see RQ2
            precond_current    <= (phase_reg == CHG_PRECOND);
        end
    end

    // ------------------------------------------------------------------------
    // status line reply
    // ------------------------------------------------------------------------
    chg_reply_e rst_reg;
    chg_reply_e rst_next;
    logic [7:0] low_cnt_reg;
    logic [7:0] low_cnt_next;
    logic [9:0] tmr_reg;
    logic [9:0] tmr_next;
    logic [4:0] left_reg;
    logic [4:0] left_next;
    logic       line_d_reg;
    logic       req_seen;

    // a request is a low lasting at least the minimum width, then released
    assign req_seen = line_s && !line_d_reg && (low_cnt_reg >= 8'(REQ_CYC));  // see RQ19

    always_comb begin
        rst_next       = rst_reg;
        tmr_next       = tmr_reg;
        left_next      = left_reg;
        low_cnt_next   = 8'h00;
        last_code_next = last_code_reg;
        if (!line_s && rst_reg == CHG_R_IDLE) begin
            low_cnt_next = (low_cnt_reg == 8'hFF) ? 8'hFF : low_cnt_reg + 8'h01;
        end
        unique case (rst_reg)
            CHG_R_IDLE: begin
                if (req_seen || sw_req) begin
                    rst_next       = CHG_R_HIGH;
                    tmr_next       = 10'(HALF_CYC - 1);
                    left_next      = code;
                    last_code_next = code;
                end
            end
            CHG_R_HIGH: begin
                if (tmr_reg == 10'h000) begin
                    if (left_reg == 5'h00) begin
                        rst_next = CHG_R_IDLE;
                    end else begin
                        rst_next  = CHG_R_LOW;                       // see RQ20
                        tmr_next  = 10'(HALF_CYC - 1);
                        left_next = left_reg - 5'h01;
                    end
                end else begin
                    tmr_next = tmr_reg - 10'h001;
                end
            end
            CHG_R_LOW: begin
                if (tmr_reg == 10'h000) begin
                    rst_next = CHG_R_HIGH;                           // see RQ21
                    tmr_next = 10'(HALF_CYC - 1);
                end else begin
                    tmr_next = tmr_reg - 10'h001;
                end
            end
            default: rst_next = CHG_R_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_reg       <= CHG_R_IDLE;
            tmr_reg       <= 10'h000;
            left_reg      <= 5'h00;
            low_cnt_reg   <= 8'h00;
            line_d_reg    <= 1'b1;
            last_code_reg <= 5'h00;
        end else begin
            rst_reg       <= rst_next;
            tmr_reg       <= tmr_next;
            left_reg      <= left_next;
            low_cnt_reg   <= low_cnt_next;
            line_d_reg    <= line_s;
            last_code_reg <= last_code_next;
        end
    end

    logic line_oe_next;
    assign line_oe_next = (rst_next == CHG_R_LOW);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_line_oe <= 1'b0;
        end else begin
            status_line_oe <= line_oe_next;
        end
    end
    assign status_line_o = 1'b0;

    // ------------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------------
    assign sw_req = wr_en && (paddr == `CHG_OFF_CTRL) && pstrb[0] &&
                    pwdata[`CHG_CTRL_REQ_BIT];

    always_comb begin
        ctrl_next   = ctrl_reg;
        prdata_next = prdata_reg;
        err_next    = 1'b0;
        if (wr_en && (paddr == `CHG_OFF_CTRL) && pstrb[0]) begin
            ctrl_next = {30'h0000_0000, pwdata[`CHG_CTRL_LVL_BIT], pwdata[`CHG_CTRL_EN_BIT]};
        end
        if (psel && !penable) begin
            err_next = !addr_ok(paddr);
        end
        if (rd_en) begin
            unique case (paddr)
                `CHG_OFF_CTRL:   prdata_next = ctrl_reg;
                `CHG_OFF_STATUS: prdata_next = {16'h0000, 3'h0, code, 1'b0,
                                                rst_reg != CHG_R_IDLE, charging,
                                                any_fault, 1'b0, phase_reg};
                `CHG_OFF_REPLY:  prdata_next = {27'h000_0000, last_code_reg};
                `CHG_OFF_INPUTS: prdata_next = {19'h0_0000, s2_reg[12:0]};
                default:         prdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= `CHG_CTRL_RST;
            prdata_reg <= 32'h0000_0000;
            err_reg    <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            prdata_reg <= prdata_next;
            err_reg    <= err_next;
        end
    end

    // no wait state: read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = psel && penable && err_reg;

endmodule

// File: dv/chg_ctrl_props.sv
// checker for the charger control block
`timescale 1ns/1ps
`include "chg_consts.svh"
module chg_ctrl_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // condition inputs
    input wire logic charge_level_select,
    input wire logic enable,
    input wire logic supply_lockout,
    input wire logic supply_sag,
    input wire logic cell_present,
    input wire logic cell_overvoltage,
    input wire logic die_overtemp,
    input wire logic therm_below_hot,
    input wire logic therm_above_cold,
    // outputs watched
    input wire logic charge_on,
    input wire logic high_current_level,
    input wire logic low_current_level,
    input wire logic reduction_active,
    input wire logic precond_current,
    input wire logic status_lamp_a_o,
    input wire logic status_lamp_a_oe,
    input wire logic status_lamp_b_o,
    input wire logic status_lamp_b_oe,
    input wire logic status_line_o,
    input wire logic status_line_oe
);
    int hi_cnt;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------------
    // reply low pulse length, counted since the line was pulled
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= status_line_oe ? hi_cnt + 1 : 0;
        end
    end
    // ------------------------------------------------------------------
    // assertions; six cycles covers sync, state and output stages
    // ------------------------------------------------------------------
    chk_off_disabled: assert property (!enable [*6] |-> !charge_on
        && !status_lamp_a_oe && !status_lamp_b_oe) else $error("active while disabled");
    chk_off_lockout: assert property (supply_lockout [*6] |-> !charge_on
        && !status_lamp_a_oe && !status_lamp_b_oe) else $error("active in lockout");
    chk_die_stop: assert property (die_overtemp [*6] |-> !charge_on)
        else $error("charging with hot die");
    chk_therm_stop: assert property ((therm_below_hot || therm_above_cold) [*6]
        |-> !charge_on) else $error("charging with thermistor fault");
    chk_ovp_stop: assert property (cell_overvoltage [*6] |-> !charge_on)
        else $error("charging in over-voltage");
    chk_fault_lamps: assert property ((enable && !supply_lockout && cell_present
        && (die_overtemp || cell_overvoltage || therm_below_hot || therm_above_cold)) [*6]
        |-> status_lamp_a_oe && status_lamp_b_oe) else $error("fault lamps not both on");
    chk_level_pick: assert property ((charge_level_select [*6] ##0 charge_on
        && !precond_current) |-> high_current_level && !low_current_level)
        else $error("wrong current level");
    chk_no_reduce: assert property (!supply_sag [*6] |-> !reduction_active)
        else $error("reduction without sag");
    chk_open_drain: assert property (!status_lamp_a_o && !status_lamp_b_o
        && !status_line_o) else $error("open drain output driven high");
    chk_pulse_width: assert property ($fell(status_line_oe) |-> hi_cnt == `CHG_HALF_CYC)
        else $error("reply pulse width wrong");
    // ------------------------------------------------------------------
    // covers
    // ------------------------------------------------------------------
    cover property ($fell(status_line_oe));
    cover property (status_lamp_a_oe && status_lamp_b_oe);
    cover property (charge_on && high_current_level);
endmodule

bind chg_ctrl chg_ctrl_props u_props (.*);

// File: dv/chg_host_model.sv
// host model: requests a status reply and counts the low pulses
`timescale 1ns/1ps
module chg_host_model (
    // clock
    input  wire logic pclk,
    // resolved line level and host pull-down
    input  wire logic line,
    output logic      host_low
);
    initial host_low = 1'b0;
    task automatic read_code(input int len, output int n);
        int   idle;
        logic prev;
        n = 0;
        idle = 0;
        prev = 1'b1;
        @(posedge pclk);
        host_low <= 1'b1;
        repeat (len) @(posedge pclk);
        host_low <= 1'b0;
        // long idle also keeps the next request clear of this reply
        while (idle < 1200) begin
            @(negedge pclk);
            if (prev === 1'b1 && line === 1'b0) n++;
            idle = (line === 1'b1) ? idle + 1 : 0;
            prev = line;
        end
    endtask
endmodule

// File: dv/tb_charger_control_fault_status.sv
// testbench for the charger control block
`timescale 1ns/1ps
`include "chg_consts.svh"
module tb_charger_control_fault_status;
    typedef struct {logic [12:0] inp; logic [2:0] exp; int code;} chg_row_s;
    localparam int LIMIT = 90000;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic [3:0]  pstrb = 4'hF;
    logic [12:0] ins = 13'h0010;
    logic pready, pslverr, e, host_low;
    logic charge_level_select, enable, supply_lockout, supply_sag, cell_present;
    logic cell_below_min, cell_at_reg, cell_below_recharge, cell_overvoltage;
    logic taper_reached, die_overtemp, therm_below_hot, therm_above_cold;
    logic charge_on, high_current_level, low_current_level, reduction_active;
    logic precond_current, status_lamp_a_o, status_lamp_a_oe, status_lamp_b_o;
    logic status_lamp_b_oe, status_line_o, status_line_oe;
    wire  status_line_i = !(host_low || status_line_oe); // pull-up when released
    int   mismatches = 0, checked = 0, tog, diff;
    // rows: inputs, {charge, lamp a, lamp b}, reply code (0 = none)
    chg_row_s rows[16] = '{'{13'h0010, 3'h0, 0}, '{13'h0033, 3'h6, 0},
        '{13'h0013, 3'h6, 0}, '{13'h0053, 3'h6, 0}, '{13'h0253, 3'h1, `CHG_CODE_HI_BASE + 4},
        '{13'h0412, 3'h3, `CHG_CODE_DIE_OT}, '{13'h0812, 3'h3, `CHG_CODE_BAT_TEMP},
        '{13'h1012, 3'h3, 0}, '{13'h0112, 3'h3, `CHG_CODE_OVP},
        '{13'h0D12, 3'h3, `CHG_CODE_DIE_OT}, '{13'h0912, 3'h3, `CHG_CODE_BAT_TEMP},
        '{13'h009A, 3'h6, `CHG_CODE_LO_BASE + 1}, '{13'h0016, 3'h0, 0},
        '{13'h0012, 3'h6, 0}, '{13'h0010, 3'h0, 0}, '{13'h0012, 3'h6, 0}};
    assign {therm_above_cold, therm_below_hot, die_overtemp, taper_reached, cell_overvoltage,
        cell_below_recharge, cell_at_reg, cell_below_min, cell_present, supply_sag,
        supply_lockout, enable, charge_level_select} = ins;
    chg_ctrl #(.FLASH_CYC(16)) dut (.*);
    chg_host_model host (.pclk(pclk), .line(status_line_i), .host_low(host_low));
    always #25 pclk = ~pclk;
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle(input logic [12:0] v);
        @(posedge pclk);
        ins <= v;
        repeat (10) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic reply(input int len, input int exp);
        int n;
        host.read_code(len, n);
        chk(n, exp);
    endtask
    task automatic end_sim();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `CHG_OFF_CTRL, 32'h0);
        chk(r, `CHG_CTRL_RST);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        foreach (rows[i]) begin
            settle(rows[i].inp);
            chk({29'h0, charge_on, status_lamp_a_oe, status_lamp_b_oe}, {29'h0, rows[i].exp});
            if (rows[i].code != 0) reply(6, rows[i].code);
            $display("row %0d done", i);
        end
        apb(1'b0, `CHG_OFF_REPLY, 32'h0);
        chk({27'h0, r[4:0]}, 32'h13);
        reply(2, 0);
        apb(1'b1, `CHG_OFF_CTRL, 32'h0);
        settle(13'h0012);
        chk({31'h0, charge_on}, 32'h0);
        apb(1'b1, `CHG_OFF_CTRL, 32'h1);
        $display("soft disable done");
        settle(13'h0002);
        tog = 0;
        diff = 0;
        repeat (64) begin
            e = status_lamp_a_oe;
            @(negedge pclk);
            if (status_lamp_a_oe !== e) tog++;
            if (status_lamp_a_oe !== status_lamp_b_oe) diff++;
        end
        chk(diff, 0);
        chk({31'h0, tog >= 3 && tog <= 5}, 32'h1);
        $display("flash test done");
        end_sim();
    end
    initial begin
        repeat (LIMIT) @(posedge pclk);
        mismatches++;
        end_sim();
    end
endmodule
